// ---- design/fpm_ctrl.sv ----
// Purpose: programmer-mode command sequencer for the on-chip flash
// Assumes: pins are asynchronous to clk_sys; flash core shares clk_sys
// Notes: strobes are sampled, so a write is seen two cycles after we_n rises
//
// Contract
// (R01) Programmer erases before reprogramming any already programmed address.
// (R02) Programmer programs each address block only once.
// (R03) Program transfers 128 bytes, pad with ff; device programs whole page.
// (R04) Page address low 7 bits must be zero; else write proceeds, error flagged.
// (R05) Programmer gives address in second cycle only, never in later cycles.
// (R06) No command write while programming runs.
// (R07) No command write while erasing runs.
// (R08) Auto-erase always erases the whole array.
// (R09) Poll bits held until next command write, readable with ce and oe low.
// (R10) Status bit low while running, high when ended; bits 0 to 5 read 0.
// (R11) Result bit high on normal end, low on abnormal end.
// (R12) Programmer confirms completion by result bit or a status read.
// (R13) Status read mode returns a code naming the abnormal end.
// (R14) Return code kept until a non status-read command write.
// (R15) Programmer waits 20 us after status read command before reading.
// (R16) Programmer waits 1 ms after final write before polling.
// (R17) Command writes ignored during oscillation and mode setup intervals.
// (R18) After setup interval the device enters memory read mode.
// (R19) Programmer allows oscillation plus 10 ms setup before first command.
// (R20) Erase recommended before programming chips of unknown history.
// (R21) Auto-program is one command cycle plus 128 data writes.
// (R22) After program, erase or status read, return to command wait; after status read the code stays in ST_STAT until the next command write.
// (R23) Commands: 00 read, 40 program, 20 twice erase, 71 twice status.
`timescale 1ns/1ps
module fpm_ctrl #(
	parameter int STARTUP_CYCLES = fpm_pkg::STARTUP_CYCLES
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// programmer pins
	input wire logic chip_enable_n,
	input wire logic output_enable_n,
	input wire logic write_enable_n,
	input wire logic [fpm_pkg::ADDR_W-1:0] addr_pin,
	input wire logic [fpm_pkg::DATA_W-1:0] data_pin_in,
	output logic [fpm_pkg::DATA_W-1:0] data_pin_out,
	output logic data_pin_oe,
	// flash core read port
	output logic [fpm_pkg::ADDR_W-1:0] core_rd_addr,
	input wire logic [fpm_pkg::DATA_W-1:0] core_rd_data,
	// flash core program and erase
	output logic core_prog_start,
	output logic [fpm_pkg::ADDR_W-1:0] core_page_addr,
	output logic core_erase_start,
	output logic core_wr_valid,
	output logic [fpm_pkg::DATA_W-1:0] core_wr_data,
	input wire logic core_wr_ready,
	input wire logic core_done,
	input wire logic core_fail,
	// status
	output logic ready,
	output logic busy
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int SW = 3 + fpm_pkg::ADDR_W + fpm_pkg::DATA_W;
	logic [SW-1:0] sync1;
	logic [SW-1:0] sync2;
	logic we_prev;
	wire [SW-1:0] pins = {chip_enable_n, output_enable_n, write_enable_n, addr_pin, data_pin_in};
	wire ce_s = ~sync2[SW-1];
	wire oe_s = ~sync2[SW-2];
	wire we_n_s = sync2[SW-3];
	wire [fpm_pkg::ADDR_W-1:0] addr_s = sync2[fpm_pkg::DATA_W +: fpm_pkg::ADDR_W];
	wire [fpm_pkg::DATA_W-1:0] data_s = sync2[fpm_pkg::DATA_W-1:0];

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sync1 <= '1;
			sync2 <= '1;
			we_prev <= 1'b1;
		end else begin
			sync1 <= pins;
			sync2 <= sync1;
			we_prev <= we_n_s;
		end
	end

	// a write cycle ends on the rising edge of write enable with chip enable low
	wire wr_cycle = ce_s && we_n_s && !we_prev;

	// ----------------------------------------------------------------
	// state and decode
	// ----------------------------------------------------------------
	fpm_pkg::fpm_state_t state;
	fpm_pkg::fpm_state_t next_state;
	logic [fpm_pkg::STARTUP_W-1:0] start_cnt;
	logic [7:0] byte_cnt;
	logic poll_status;
	logic poll_result;
	logic [7:0] ret_code;
	logic page_err;
	logic overrun;

	// command wait and memory read both accept a first command byte
	function automatic logic cmd_wait(fpm_pkg::fpm_state_t s);
		return s == fpm_pkg::ST_READ || s == fpm_pkg::ST_CMD;
	endfunction

	// status read mode takes commands too, else the next command byte would be lost
	wire cmd_ok = cmd_wait(state) || state == fpm_pkg::ST_STAT;
	wire cmd_wr = cmd_ok && wr_cycle;
	wire start_done = start_cnt == fpm_pkg::STARTUP_W'(STARTUP_CYCLES - 1);
	wire first_byte = byte_cnt == 8'h00;
	wire last_byte = byte_cnt == fpm_pkg::PAGE_LAST;
	wire data_wr = state == fpm_pkg::ST_PROG_DATA && wr_cycle;
	wire addr_bad = addr_s[fpm_pkg::PAGE_LSB-1:0] != '0;
	wire prog_end = state == fpm_pkg::ST_PROG_RUN && core_done;
	wire erase_end = state == fpm_pkg::ST_ERASE_RUN && core_done;
	wire prog_bad = core_fail || page_err || overrun;
	wire stat_cmd = cmd_wr && data_s == fpm_pkg::CMD_STAT;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [fpm_pkg::DATA_W-1:0] fifo_out_data;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			fpm_pkg::ST_STARTUP: begin
				if (start_done) begin
					next_state = fpm_pkg::ST_READ; // R18
				end
			end
			fpm_pkg::ST_READ, fpm_pkg::ST_CMD, fpm_pkg::ST_STAT: begin
				if (cmd_wr) begin
					unique case (data_s) // R23
						fpm_pkg::CMD_READ: next_state = fpm_pkg::ST_READ;
						fpm_pkg::CMD_PROG: next_state = fpm_pkg::ST_PROG_DATA;
						fpm_pkg::CMD_ERASE: next_state = fpm_pkg::ST_ERASE2;
						fpm_pkg::CMD_STAT: next_state = fpm_pkg::ST_STAT2;
						default: next_state = fpm_pkg::ST_CMD;
					endcase
				end
			end
			fpm_pkg::ST_PROG_DATA: begin
				if (data_wr && last_byte) begin
					next_state = fpm_pkg::ST_PROG_RUN; // R21
				end
			end
			fpm_pkg::ST_ERASE2: begin
				if (wr_cycle) begin
					next_state = data_s == fpm_pkg::CMD_ERASE ? fpm_pkg::ST_ERASE_RUN : fpm_pkg::ST_CMD; // R23
				end
			end
			fpm_pkg::ST_STAT2: begin
				if (wr_cycle) begin
					next_state = data_s == fpm_pkg::CMD_STAT ? fpm_pkg::ST_STAT : fpm_pkg::ST_CMD; // R23
				end
			end
			fpm_pkg::ST_PROG_RUN, fpm_pkg::ST_ERASE_RUN: begin
				// writes here are not decoded at all
				if (core_done) begin
					next_state = fpm_pkg::ST_CMD; // R06 R07 R22
				end
			end
			// spare codes of the state register fall back to command wait
			default: begin
				next_state = fpm_pkg::ST_CMD;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// sequencer registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state <= fpm_pkg::ST_STARTUP;
			start_cnt <= '0;
		end else begin
			state <= next_state;
			// nothing is decoded while counting, so early writes are lost
			if (state == fpm_pkg::ST_STARTUP) begin
				start_cnt <= start_cnt + 1'b1; // R17
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			byte_cnt <= '0;
			page_err <= 1'b0;
			overrun <= 1'b0;
			core_page_addr <= '0;
			core_prog_start <= 1'b0;
		end else begin
			core_prog_start <= data_wr && first_byte;
			if (cmd_wr) begin
				byte_cnt <= '0;
				page_err <= 1'b0;
				overrun <= 1'b0;
			end else if (data_wr) begin
				byte_cnt <= byte_cnt + 1'b1;
				// address only taken on the first data write
				if (first_byte) begin
					core_page_addr <= {addr_s[fpm_pkg::ADDR_W-1:fpm_pkg::PAGE_LSB], fpm_pkg::PAGE_LSB'(0)}; // R05
					page_err <= addr_bad; // R04
				end
				// bytes cannot be stalled at the pins, so a full fifo is a fault
				if (!fifo_in_ready) begin
					overrun <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// polling bits and return code
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			poll_status <= 1'b0;
			poll_result <= 1'b0;
			ret_code <= fpm_pkg::RC_NONE;
			core_erase_start <= 1'b0;
		end else begin
			core_erase_start <= state == fpm_pkg::ST_ERASE2 && wr_cycle && data_s == fpm_pkg::CMD_ERASE; // R08
			if (prog_end) begin
				poll_status <= 1'b1; // R10
				poll_result <= !prog_bad; // R11
				ret_code <= (core_fail ? fpm_pkg::RC_PROG_FAIL : fpm_pkg::RC_NONE)
					| (page_err ? fpm_pkg::RC_ADDR_ERR : fpm_pkg::RC_NONE)
					| (overrun ? fpm_pkg::RC_OVERRUN : fpm_pkg::RC_NONE); // R13
			end else if (erase_end) begin
				poll_status <= 1'b1; // R10
				poll_result <= !core_fail; // R11
				ret_code <= core_fail ? fpm_pkg::RC_ERASE_FAIL : fpm_pkg::RC_NONE; // R13
			end else if (cmd_wr) begin
				// held until here, then low while any new operation runs
				poll_status <= 1'b0; // R09 R10
				poll_result <= 1'b0;
				if (!stat_cmd) begin
					ret_code <= fpm_pkg::RC_NONE; // R14
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// page data fifo
	// ----------------------------------------------------------------
	fpm_fifo #(
		.WIDTH(fpm_pkg::DATA_W),
		.DEPTH(fpm_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_valid(data_wr), // R03
		.in_data(data_s),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(core_wr_ready)
	);

	assign core_wr_valid = fifo_out_valid;
	assign core_wr_data = fifo_out_data;

	// ----------------------------------------------------------------
	// read data path
	// ----------------------------------------------------------------
	wire reading = ce_s && oe_s && we_n_s;
	wire [7:0] poll_byte = {poll_status, poll_result, 6'h00}; // R10
	wire [7:0] rd_sel = state == fpm_pkg::ST_READ ? core_rd_data
		: state == fpm_pkg::ST_STAT ? ret_code
		: poll_byte;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			data_pin_out <= '0;
			data_pin_oe <= 1'b0;
			core_rd_addr <= '0;
		end else begin
			core_rd_addr <= addr_s;
			data_pin_oe <= reading && state != fpm_pkg::ST_STARTUP;
			data_pin_out <= rd_sel; // R09
		end
	end

	// ----------------------------------------------------------------
	// handshake flags
	// ----------------------------------------------------------------
	// taken from the next state so the flags change on the same edge as the state
	wire next_wait = cmd_wait(next_state);
	wire next_run = next_state == fpm_pkg::ST_PROG_RUN || next_state == fpm_pkg::ST_ERASE_RUN;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ready <= 1'b0;
			busy <= 1'b0;
		end else begin
			ready <= next_wait; // R18 R22
			busy <= next_run;
		end
	end
endmodule // fpm_ctrl

// ---- design/fpm_pkg.sv ----
// Purpose: shared constants for the programmer-mode flash command sequencer
// Assumes: 40 MHz system clock, byte-wide programmer bus, 32 kbyte array
// Notes: every number of the block lives here once
package fpm_pkg;

	// ----------------------------------------------------------------
	// bus widths and page geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int PAGE_LSB = 7;
	localparam int PAGE_BYTES = 128;
	localparam int FIFO_DEPTH = 8;
	localparam logic [7:0] PAGE_LAST = 8'h7f;
	localparam logic [7:0] PAD_BYTE = 8'hff;

	// ----------------------------------------------------------------
	// first-cycle command bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CMD_PROG = 8'h40;
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [7:0] CMD_STAT = 8'h71;

	// ----------------------------------------------------------------
	// status read return code bits, zero means no fault
	// ----------------------------------------------------------------
	localparam logic [7:0] RC_NONE = 8'h00;
	localparam logic [7:0] RC_ADDR_ERR = 8'h01;
	localparam logic [7:0] RC_OVERRUN = 8'h02;
	localparam logic [7:0] RC_PROG_FAIL = 8'h10;
	localparam logic [7:0] RC_ERASE_FAIL = 8'h20;

	// ----------------------------------------------------------------
	// startup timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 40000000;
	localparam int T_OSC_MS = 10;
	localparam int T_SETUP_MS = 10;
	localparam int STARTUP_CYCLES = (T_OSC_MS + T_SETUP_MS) * (CLK_HZ / 1000);
	localparam int STARTUP_W = 20;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_STARTUP,
		ST_READ,
		ST_CMD,
		ST_PROG_DATA,
		ST_PROG_RUN,
		ST_ERASE2,
		ST_ERASE_RUN,
		ST_STAT2,
		ST_STAT
	} fpm_state_t;

endpackage

// ---- design/fpm_fifo.sv ----
// Purpose: small synchronous FIFO between programmer pins and the flash core
// Assumes: one clock, writes offered while in_ready is low are dropped by the fifo itself
// Notes: valid and ready flags are registered from the next occupancy
`timescale 1ns/1ps
module fpm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// filling side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// draining side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	logic [PW:0] next_count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign next_count = count + (PW+1)'(push) - (PW+1)'(pop);
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			wr_ptr <= push ? PW'(wr_ptr + 1'b1) : wr_ptr;
			rd_ptr <= pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
			count <= next_count;
			in_ready <= next_count != (PW+1)'(DEPTH);
			out_valid <= next_count != '0;
		end
	end
endmodule // fpm_fifo

// ---- bench/fpm_ctrl_asserts.sv ----
// Purpose: pin level assertions for the flash command sequencer
// Assumes: bound to fpm_ctrl, one clock domain
// Notes: startup count follows the bound parameter
`timescale 1ns/1ps
module fpm_ctrl_asserts #(
	parameter int STARTUP_CYCLES = 50
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// programmer pins
	input wire logic chip_enable_n,
	input wire logic output_enable_n,
	input wire logic write_enable_n,
	input wire logic [7:0] data_pin_out,
	input wire logic data_pin_oe,
	// core side and status
	input wire logic core_prog_start,
	input wire logic [14:0] core_page_addr,
	input wire logic core_erase_start,
	input wire logic core_done,
	input wire logic core_fail,
	input wire logic ready,
	input wire logic busy
);
	// ----
	// cycles since reset release, saturating
	// ----
	int cnt;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk_sys) begin
		if (!rst_n) cnt <= 0;
		else if (cnt < 1000000) cnt <= cnt + 1;
	end
	property p_ign; cnt < STARTUP_CYCLES - 1 |-> !ready && !busy && !core_erase_start; endproperty
	a_ign: assert property (p_ign) else $error("activity during startup");
	property p_rdy; cnt == STARTUP_CYCLES + 6 |-> ready; endproperty
	a_rdy: assert property (p_rdy) else $error("not ready after startup");
	property p_addr; core_prog_start |-> core_page_addr[6:0] == 7'h00; endproperty
	a_addr: assert property (p_addr) else $error("page base not aligned");
	property p_ers; core_erase_start |-> ##[0:2] busy; endproperty
	a_ers: assert property (p_ers) else $error("erase without busy");
	property p_done; busy && core_done |-> ##[1:2] (!busy && ready); endproperty
	a_done: assert property (p_done) else $error("no return to command wait");
	property p_run; busy && $past(busy) && $past(busy, 2) && data_pin_oe |-> data_pin_out == 8'h00; endproperty
	a_run: assert property (p_run) else $error("poll byte wrong while running");
	property p_oe; (!chip_enable_n && !output_enable_n && write_enable_n) [*5] |-> data_pin_oe; endproperty
	a_oe: assert property (p_oe) else $error("poll byte not readable");
	property p_off; chip_enable_n [*4] |-> !data_pin_oe; endproperty
	a_off: assert property (p_off) else $error("driving while deselected");
	property p_prog; core_prog_start |-> !busy; endproperty
	a_prog: assert property (p_prog) else $error("page start while busy");
	c_prog: cover property (core_prog_start);
	c_erase: cover property (core_erase_start);
	c_fail: cover property (busy && core_done && core_fail);
endmodule // fpm_ctrl_asserts
bind fpm_ctrl fpm_ctrl_asserts #(.STARTUP_CYCLES(STARTUP_CYCLES)) fpm_ctrl_asserts_inst (
	.clk_sys(clk_sys), .rst_n(rst_n), .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
	.write_enable_n(write_enable_n), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
	.core_prog_start(core_prog_start), .core_page_addr(core_page_addr), .core_erase_start(core_erase_start),
	.core_done(core_done), .core_fail(core_fail), .ready(ready), .busy(busy)
);

// ---- bench/fpm_prog_model.sv ----
// Purpose: programmer side of the pin bus
// Assumes: tasks called one at a time
// Notes: released lines show the inverse of the last value
`timescale 1ns/1ps
module fpm_prog_model (
	// clock
	input wire logic clk_sys,
	// pins driven
	output logic chip_enable_n,
	output logic output_enable_n,
	output logic write_enable_n,
	output logic [14:0] addr_pin,
	output logic [7:0] data_pin_in,
	// pins read
	input wire logic [7:0] data_pin_out,
	input wire logic data_pin_oe
);
	initial begin
		chip_enable_n = 1;
		output_enable_n = 1;
		write_enable_n = 1;
		addr_pin = 15'h0000;
		data_pin_in = 8'h00;
	end
	// spacing of 9 cycles keeps clear of the sync pipeline
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#2;
		chip_enable_n = 0;
		write_enable_n = 0;
		addr_pin = a;
		data_pin_in = d;
		repeat (3) @(posedge clk_sys);
		#2 write_enable_n = 1;
		repeat (3) @(posedge clk_sys);
		#2 chip_enable_n = 1;
		addr_pin = ~a;
		data_pin_in = ~d;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic rd(input logic [14:0] a, output logic [8:0] q);
		@(posedge clk_sys);
		#2;
		chip_enable_n = 0;
		output_enable_n = 0;
		addr_pin = a;
		repeat (6) @(posedge clk_sys);
		q = {data_pin_oe, data_pin_out};
		#2 chip_enable_n = 1;
		output_enable_n = 1;
		addr_pin = ~a;
		repeat (3) @(posedge clk_sys);
	endtask
endmodule // fpm_prog_model

// ---- bench/fpm_ctrl_tb_top.sv ----
// Purpose: self-checking bench for the flash command sequencer
// Assumes: short startup count of 50 cycles
// Notes: flash core modelled inline, done comes dly+1 cycles after busy
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin num_errors++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module fpm_ctrl_tb_top;
	typedef struct packed {
		logic op;
		logic [14:0] a;
		logic fl;
		logic st;
		logic [7:0] poll;
		logic [7:0] rc;
	} fpm_row_t;
	logic clk_sys = 0, rst_n = 0, stall = 0, fail_inj = 0, bd = 0, core_done = 0;
	logic chip_enable_n, output_enable_n, write_enable_n, data_pin_oe, core_prog_start, core_erase_start;
	logic core_wr_valid, core_wr_ready, core_fail, ready, busy;
	logic [14:0] addr_pin, core_rd_addr, core_page_addr, pg = 0;
	logic [7:0] data_pin_in, data_pin_out, core_rd_data, core_wr_data, tmr = 0, dly = 20;
	logic [7:0] mem [32768];
	logic [6:0] idx = 0;
	logic [8:0] q;
	int num_errors = 0, checks = 0, cyc = 0;
	// erase first, each page once, last one overruns the stalled fifo
	fpm_row_t rows [6] = '{
		'{1'b0, 15'h0000, 1'b0, 1'b0, 8'hc0, 8'h00}, '{1'b1, 15'h0080, 1'b0, 1'b0, 8'hc0, 8'h00},
		'{1'b1, 15'h0105, 1'b0, 1'b0, 8'h80, 8'h01}, '{1'b0, 15'h0000, 1'b1, 1'b0, 8'h80, 8'h20},
		'{1'b1, 15'h0200, 1'b1, 1'b0, 8'h80, 8'h10}, '{1'b1, 15'h0280, 1'b0, 1'b1, 8'h80, 8'h02}};
	always #12.5 clk_sys = ~clk_sys;
	fpm_ctrl #(.STARTUP_CYCLES(50)) fpm_ctrl_inst (
		.clk_sys(clk_sys), .rst_n(rst_n), .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
		.write_enable_n(write_enable_n), .addr_pin(addr_pin), .data_pin_in(data_pin_in),
		.data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .core_rd_addr(core_rd_addr),
		.core_rd_data(core_rd_data), .core_prog_start(core_prog_start), .core_page_addr(core_page_addr),
		.core_erase_start(core_erase_start), .core_wr_valid(core_wr_valid), .core_wr_data(core_wr_data),
		.core_wr_ready(core_wr_ready), .core_done(core_done), .core_fail(core_fail), .ready(ready), .busy(busy)
	);
	fpm_prog_model fpm_prog_model_inst (
		.clk_sys(clk_sys), .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
		.write_enable_n(write_enable_n), .addr_pin(addr_pin), .data_pin_in(data_pin_in),
		.data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe)
	);
	// ----
	// flash core
	// ----
	assign core_rd_data = mem[core_rd_addr];
	assign core_wr_ready = !stall && cyc[0] && !core_prog_start;
	assign core_fail = fail_inj;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		bd <= busy;
		core_done <= 0;
		if (core_prog_start) begin
			pg <= core_page_addr;
			idx <= 0;
		end
		if (core_wr_valid && core_wr_ready) begin
			mem[pg + 15'(idx)] <= core_wr_data;
			idx <= idx + 1;
		end
		if (core_erase_start) foreach (mem[i]) mem[i] <= 8'hff;
		if (busy && !bd) tmr <= dly;
		if (tmr == 1) core_done <= 1;
		if (tmr != 0) tmr <= tmr - 1;
		if (cyc > 40000) begin
			num_errors++;
			final_report();
		end
	end
	task automatic w(input logic [14:0] a, input logic [7:0] d);
		fpm_prog_model_inst.wr(a, d);
	endtask
	task automatic r(input logic [14:0] a);
		fpm_prog_model_inst.rd(a, q);
	endtask
	task automatic wt(input int n);
		for (int k = 0; k < n && (ready !== 1'b1 || busy !== 1'b0); k++) @(posedge clk_sys);
	endtask
	task automatic rst();
		#2 rst_n = 0;
		repeat (12) @(posedge clk_sys);
		#2 rst_n = 1;
	endtask
	task automatic run(input fpm_row_t t);
		#2 fail_inj = t.fl;
		stall = t.st;
		if (t.op) begin
			w(15'h0000, fpm_pkg::CMD_PROG);
			for (int i = 0; i < 128; i++) begin
				w(i == 0 ? t.a : 15'h0000, i < 120 ? 8'(i * 3) : fpm_pkg::PAD_BYTE);
				if (i == 12) #2 stall = 0;
			end
		end else begin
			w(15'h0000, fpm_pkg::CMD_ERASE);
			w(15'h0000, fpm_pkg::CMD_ERASE);
		end
		wt(400);
		r(15'h0000);
		`CHK("poll", {1'b1, t.poll}, q)
		r(15'h0000);
		`CHK("poll_hold", {1'b1, t.poll}, q)
		w(15'h0000, fpm_pkg::CMD_STAT);
		w(15'h0000, fpm_pkg::CMD_STAT);
		repeat (800) @(posedge clk_sys);
		r(15'h0000);
		`CHK("code", {1'b1, t.rc}, q)
		r(15'h0000);
		`CHK("code_hold", {1'b1, t.rc}, q)
		if (t.op && t.rc == 8'h00) begin
			w(15'h0000, fpm_pkg::CMD_READ);
			r(t.a + 15'h0001);
			`CHK("data", 9'h103, q)
			r(t.a + 15'h007f);
			`CHK("pad", 9'h1ff, q)
		end
		#2 fail_inj = 0;
	endtask
	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		rst();
		wt(100);
		`CHK("ready", 1'b1, ready)
		r(15'h0000);
		`CHK("read_mode", 9'h1ff, q)
		foreach (rows[n]) run(rows[n]);
		// ----
		// erase issued inside the startup window is dropped
		// ----
		rst();
		w(15'h0000, fpm_pkg::CMD_ERASE);
		w(15'h0000, fpm_pkg::CMD_ERASE);
		`CHK("startup_busy", 1'b0, busy)
		wt(200);
		r(15'h0201);
		`CHK("boot_read", 9'h103, q)
		// ----
		// slow erase with a command write during the run
		// ----
		#2 dly = 250;
		w(15'h0000, fpm_pkg::CMD_ERASE);
		w(15'h0000, fpm_pkg::CMD_ERASE);
		r(15'h0000);
		`CHK("running", 9'h100, q)
		w(15'h0000, fpm_pkg::CMD_STAT);
		wt(400);
		r(15'h0000);
		`CHK("ignored", 9'h1c0, q)
		// ----
		// unknown command and a broken erase pair both end in command wait
		// ----
		w(15'h0000, 8'h55);
		r(15'h0000);
		`CHK("unknown_cmd", 9'h100, q)
		w(15'h0000, fpm_pkg::CMD_ERASE);
		w(15'h0000, fpm_pkg::CMD_READ);
		`CHK("erase_abort", 1'b0, busy)
		r(15'h0000);
		`CHK("abort_wait", 9'h100, q)
		final_report();
	end
endmodule // fpm_ctrl_tb_top
